/* rtl/adc_out_pkg.sv */
// Constants and types for the sample output and configuration stage
// Overview of operation
// RQ1 - CMOS mode drives all sample bits in parallel, one sample per clock.
// RQ2 - Receiver captures CMOS words on the rising edge of the sample clock.
// RQ3 - Multiplexed mode interleaves both channels on bus B, bus A floats.
// RQ4 - Controller selects multiplexed mode only below 80 mega-samples per second.
// RQ5 - Multiplexed mode entered from register field or from the power pins.
// RQ6 - Coding is twos complement or offset binary, by register or strap.
// RQ7 - Positive overdrive clamps to 3fff offset binary, 1fff twos complement.
// RQ8 - Negative overdrive clamps to 0000 offset binary, 2000 twos complement.
// RQ9 - Reset pin high: modes come straight from the strap pins.
// RQ10 - Reset pin low: registers reset first, pins act as serial port.
// RQ11 - Registers return to defaults on reset pulse or software reset bit.
// RQ12 - Combined mode applies power pins while serial sets other settings.
// RQ13 - Serial clock strap low disables, high enables low-speed mode.
// RQ14 - Enable level decodes to coding and CMOS or LVDS output.
// RQ15 - Data and clock LVDS drive doubled by two separate bits.
// RQ16 - LVDS swing comes from a register field, nominal after reset.
// RQ17 - LVDS sends even bits on rising, odd bits on falling clock edge.
// RQ18 - Pins 111 multiplex, 100 global power-down, 101 channel A standby.
// RQ19 - Twos complement is offset binary with the top bit inverted.
`default_nettype none
package adc_out_pkg;
  localparam int SAMPLE_W = 14;
  localparam int SWING_W  = 6;
  localparam logic [SAMPLE_W-1:0] OB_POS_FULL = 14'h3fff;
  localparam logic [SAMPLE_W-1:0] OB_NEG_FULL = 14'h0000;
  localparam logic [SAMPLE_W-1:0] TC_POS_FULL = 14'h1fff;
  localparam logic [SAMPLE_W-1:0] TC_NEG_FULL = 14'h2000;
  localparam logic [SWING_W-1:0]  SWING_NOMINAL = 6'h00;
  localparam logic [2:0] PINS_GLOBAL_PD = 3'h4;
  localparam logic [2:0] PINS_A_STANDBY = 3'h5;
  localparam logic [2:0] PINS_MUX       = 3'h7;
  // Enable pin level classes: gnd, 3/8, 5/8, supply
  localparam logic [1:0] LEVEL_GND    = 2'h0;
  localparam logic [1:0] LEVEL_3_8    = 2'h1;
  localparam logic [1:0] LEVEL_5_8    = 2'h2;
  localparam logic [1:0] LEVEL_SUPPLY = 2'h3;

  typedef enum logic [1:0] {CFG_PARALLEL, CFG_SERIAL, CFG_COMBINED} cfg_mode_t;

  typedef struct packed {
    logic                twos_comp;
    logic                lvds;
    logic                low_speed;
    logic                mux;
    logic                global_pd;
    logic                a_standby;
    logic                data_double;
    logic                clock_double;
    logic [SWING_W-1:0]  swing;
  } out_cfg_t;

  typedef struct packed {
    logic                twos_comp;
    logic                lvds;
    logic                low_speed;
    logic [1:0]          pd_mode;
    logic                data_double;
    logic                clock_double;
    logic [SWING_W-1:0]  swing;
  } serial_regs_t;

  localparam serial_regs_t REG_DEFAULT = '{1'b0, 1'b0, 1'b0, 2'h0, 1'b0, 1'b0, SWING_NOMINAL};
  localparam logic [1:0] PD_MODE_MUX = 2'h3;
  localparam logic [1:0] PD_MODE_GLOBAL = 2'h1;
  localparam logic [1:0] PD_MODE_STANDBY = 2'h2;
endpackage
`default_nettype wire

/* rtl/adc_output_format_and_config.sv */
// Output formatting, channel multiplexing and configuration selection
`timescale 1ns/1ps
`default_nettype none
module adc_output_format_and_config #(
  parameter int SAMPLE_W = adc_out_pkg::SAMPLE_W
) (
  input  wire logic                              i_clock,
  input  wire logic                              i_reset_n,
  input  wire logic                              i_reset_pin,
  input  wire logic                              i_sample_valid,
  input  wire logic [SAMPLE_W-1:0]               i_chan_a_sample,
  input  wire logic [SAMPLE_W-1:0]               i_chan_b_sample,
  input  wire logic                              i_chan_a_over_pos,
  input  wire logic                              i_chan_a_over_neg,
  input  wire logic                              i_chan_b_over_pos,
  input  wire logic                              i_chan_b_over_neg,
  input  wire logic [1:0]                        i_serial_enable_level,
  input  wire logic                              i_serial_clock_pin,
  input  wire logic                              i_power_ctrl_pin_1,
  input  wire logic                              i_power_ctrl_pin_2,
  input  wire logic                              i_power_ctrl_pin_3,
  input  wire logic                              i_reg_write,
  input  wire adc_out_pkg::serial_regs_t         i_reg_data,
  input  wire logic                              i_soft_reset,
  output logic [SAMPLE_W-1:0]                    o_chan_a_data_bus,
  output logic                                   o_chan_a_data_bus_oe,
  output logic [SAMPLE_W-1:0]                    o_chan_b_data_bus,
  output logic                                   o_chan_b_data_bus_oe,
  output logic                                   o_sample_out_clock,
  output logic [SAMPLE_W/2-1:0]                  o_lvds_a_pairs,
  output logic [SAMPLE_W/2-1:0]                  o_lvds_b_pairs,
  output logic                                   o_sample_out_clock_pos,
  output adc_out_pkg::out_cfg_t                  o_cfg
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [7:0] sync1;
  logic [7:0] sync2;
  logic [7:0] pins_raw;
  assign pins_raw = {i_reset_pin, i_serial_enable_level, i_serial_clock_pin,
                     i_power_ctrl_pin_1, i_power_ctrl_pin_2, i_power_ctrl_pin_3, 1'b0};
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      sync1 <= 8'h00;
      sync2 <= 8'h00;
    end else begin
      sync1 <= pins_raw;
      sync2 <= sync1;
    end
  end

  logic       rst_pin_s;
  logic [1:0] level_s;
  logic       sclk_s;
  logic [2:0] ctrl_s;
  assign rst_pin_s = sync2[7];
  assign level_s   = sync2[6:5];
  assign sclk_s    = sync2[4];
  assign ctrl_s    = sync2[3:1];

  // ----------------------------------------------------------------
  // Configuration mode and serial registers
  // ----------------------------------------------------------------
  adc_out_pkg::cfg_mode_t    cfg_mode;
  adc_out_pkg::cfg_mode_t    next_cfg_mode;
  adc_out_pkg::serial_regs_t regs;
  adc_out_pkg::serial_regs_t next_regs;
  logic                      rst_pin_d;
  logic                      next_rst_pin_d;

  always_comb begin
    next_rst_pin_d    = rst_pin_s;
    next_regs         = regs;
    next_cfg_mode     = cfg_mode;
    // RQ9 parallel when reset held high
    if (rst_pin_s) begin
      next_cfg_mode = adc_out_pkg::CFG_PARALLEL;
    // RQ12 combined when pins used
    end else if (ctrl_s != 3'h0) begin
      next_cfg_mode = adc_out_pkg::CFG_COMBINED;
    // RQ10 serial only otherwise
    end else begin
      next_cfg_mode = adc_out_pkg::CFG_SERIAL;
    end
    // RQ11 pulse falling edge or soft bit
    if ((rst_pin_d && !rst_pin_s) || i_soft_reset) begin
      next_regs = adc_out_pkg::REG_DEFAULT;
    end else if (i_reg_write && !rst_pin_s) begin
      next_regs = i_reg_data;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      cfg_mode     <= adc_out_pkg::CFG_SERIAL;
      regs         <= adc_out_pkg::REG_DEFAULT;
      rst_pin_d    <= 1'b0;
    end else begin
      cfg_mode     <= next_cfg_mode;
      regs         <= next_regs;
      rst_pin_d    <= next_rst_pin_d;
    end
  end

  // ----------------------------------------------------------------
  // Effective configuration
  // ----------------------------------------------------------------
  adc_out_pkg::out_cfg_t cfg;
  adc_out_pkg::out_cfg_t next_cfg;

  always_comb begin
    next_cfg.twos_comp    = regs.twos_comp;
    next_cfg.lvds         = regs.lvds;
    next_cfg.low_speed    = regs.low_speed;
    // RQ15 RQ16 drive and swing from registers
    next_cfg.data_double  = regs.data_double;
    next_cfg.clock_double = regs.clock_double;
    next_cfg.swing        = regs.swing;
    next_cfg.mux          = (regs.pd_mode == adc_out_pkg::PD_MODE_MUX);
    next_cfg.global_pd    = (regs.pd_mode == adc_out_pkg::PD_MODE_GLOBAL);
    next_cfg.a_standby    = (regs.pd_mode == adc_out_pkg::PD_MODE_STANDBY);
    if (cfg_mode == adc_out_pkg::CFG_PARALLEL) begin
      // RQ13 low-speed from clock strap
      next_cfg.low_speed = sclk_s;
      // RQ14 enable level decode
      next_cfg.twos_comp = (level_s == adc_out_pkg::LEVEL_GND) ||
                           (level_s == adc_out_pkg::LEVEL_SUPPLY);
      next_cfg.lvds      = (level_s == adc_out_pkg::LEVEL_5_8) ||
                           (level_s == adc_out_pkg::LEVEL_SUPPLY);
      next_cfg.data_double  = 1'b0;
      next_cfg.clock_double = 1'b0;
      next_cfg.swing        = adc_out_pkg::SWING_NOMINAL;
    end
    if (cfg_mode != adc_out_pkg::CFG_SERIAL) begin
      // RQ18 power pin decode
      // RQ5 pins or register select mux
      next_cfg.mux       = next_cfg.mux || (ctrl_s == adc_out_pkg::PINS_MUX);
      next_cfg.global_pd = next_cfg.global_pd || (ctrl_s == adc_out_pkg::PINS_GLOBAL_PD);
      next_cfg.a_standby = next_cfg.a_standby || (ctrl_s == adc_out_pkg::PINS_A_STANDBY);
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      cfg <= '0;
    end else begin
      cfg <= next_cfg;
    end
  end
  assign o_cfg = cfg;

  // ----------------------------------------------------------------
  // Sample coding
  // ----------------------------------------------------------------
  // RQ7 RQ8 RQ19 clamp and recode
  function automatic logic [SAMPLE_W-1:0] code_sample(
    input logic [SAMPLE_W-1:0] ob, input logic pos, input logic neg, input logic tc);
    logic [SAMPLE_W-1:0] v;
    v = pos ? adc_out_pkg::OB_POS_FULL : (neg ? adc_out_pkg::OB_NEG_FULL : ob);
    code_sample = tc ? {~v[SAMPLE_W-1], v[SAMPLE_W-2:0]} : v;
  endfunction

  logic [SAMPLE_W-1:0] word_a;
  logic [SAMPLE_W-1:0] word_b;
  logic [SAMPLE_W-1:0] next_word_a;
  logic [SAMPLE_W-1:0] next_word_b;
  logic [SAMPLE_W-1:0] held_a;
  logic [SAMPLE_W-1:0] next_held_a;
  logic                clk_out;
  logic                next_clk_out;

  always_comb begin
    next_word_a  = word_a;
    next_word_b  = word_b;
    next_held_a  = held_a;
    next_clk_out = 1'b0;
    if (i_sample_valid) begin
      // RQ6 coding from config
      next_word_a = code_sample(i_chan_a_sample, i_chan_a_over_pos, i_chan_a_over_neg,
                                cfg.twos_comp);
      next_word_b = code_sample(i_chan_b_sample, i_chan_b_over_pos, i_chan_b_over_neg,
                                cfg.twos_comp);
      next_clk_out = 1'b1;
      if (cfg.mux) begin
        // RQ3 interleave on bus B
        next_held_a = next_word_a;
      end
    end else if (cfg.mux && clk_out) begin
      next_word_b  = held_a;
      next_clk_out = 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      word_a  <= '0;
      word_b  <= '0;
      held_a  <= '0;
      clk_out <= 1'b0;
    end else begin
      word_a  <= next_word_a;
      word_b  <= next_word_b;
      held_a  <= next_held_a;
      clk_out <= next_clk_out;
    end
  end

  // ----------------------------------------------------------------
  // Output drivers
  // ----------------------------------------------------------------
  logic outs_on;
  assign outs_on = !cfg.global_pd;
  // RQ1 parallel CMOS words
  assign o_chan_b_data_bus    = word_b;
  assign o_chan_a_data_bus    = word_a;
  // RQ3 bus A floats in mux mode
  assign o_chan_a_data_bus_oe = outs_on && !cfg.lvds && !cfg.mux && !cfg.a_standby;
  assign o_chan_b_data_bus_oe = outs_on && !cfg.lvds;
  assign o_sample_out_clock   = clk_out;
  assign o_sample_out_clock_pos = clk_out && cfg.lvds && outs_on;

  // RQ17 even bits high phase, odd low
  always_comb begin
    for (int i = 0; i < SAMPLE_W/2; i++) begin
      o_lvds_a_pairs[i] = clk_out ? word_a[2*i] : word_a[2*i+1];
      o_lvds_b_pairs[i] = clk_out ? word_b[2*i] : word_b[2*i+1];
    end
  end

endmodule // adc_output_format_and_config
`default_nettype wire

/* testbench/adc_out_assertions.sv */
// Concurrent checks on the output stage ports
`timescale 1ns/1ps
`default_nettype none
module adc_out_checker #(
  parameter int SAMPLE_W = 14
) (
  input wire logic                      i_clock,
  input wire logic                      i_reset_n,
  input wire logic                      i_reset_pin,
  input wire logic                      i_sample_valid,
  input wire logic [SAMPLE_W-1:0]       i_chan_a_sample,
  input wire logic [SAMPLE_W-1:0]       i_chan_b_sample,
  input wire logic                      i_chan_a_over_pos,
  input wire logic                      i_chan_a_over_neg,
  input wire logic                      i_chan_b_over_pos,
  input wire logic                      i_chan_b_over_neg,
  input wire logic [1:0]                i_serial_enable_level,
  input wire logic                      i_serial_clock_pin,
  input wire logic                      i_power_ctrl_pin_1,
  input wire logic                      i_power_ctrl_pin_2,
  input wire logic                      i_power_ctrl_pin_3,
  input wire logic                      i_reg_write,
  input wire adc_out_pkg::serial_regs_t i_reg_data,
  input wire logic                      o_chan_a_data_bus_oe,
  input wire logic [SAMPLE_W-1:0]       o_chan_b_data_bus,
  input wire logic                      o_sample_out_clock,
  input wire adc_out_pkg::out_cfg_t     o_cfg
);
  logic [SAMPLE_W-1:0] flip;
  logic [2:0]          strap;
  logic                live;
  logic [SAMPLE_W-1:0] a_ob;
  assign a_ob = i_chan_a_over_pos ? adc_out_pkg::OB_POS_FULL :
                (i_chan_a_over_neg ? adc_out_pkg::OB_NEG_FULL : i_chan_a_sample);
  assign flip = o_cfg.twos_comp ? {1'b1, {(SAMPLE_W-1){1'b0}}} : '0;
  assign strap = {i_serial_enable_level, i_serial_clock_pin};
  assign live = !o_cfg.mux && !o_cfg.global_pd;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  sequence s_mux_take;
    o_cfg.mux && i_sample_valid;
  endsequence
  sequence s_pair_out;
    o_sample_out_clock ##1 !o_sample_out_clock && o_chan_b_data_bus == ($past(a_ob, 2) ^ flip);
  endsequence
  a_mux_a_float: assert property (o_cfg.mux |-> !o_chan_a_data_bus_oe)
    else $error("bus A driven in mux mode");
  a_mux_pair: assert property (s_mux_take |=> s_pair_out)
    else $error("mux word pair wrong");
  a_word_clock: assert property (i_sample_valid && !o_cfg.global_pd |=> o_sample_out_clock)
    else $error("no output clock after sample");
  a_pos_clamp: assert property (i_sample_valid && i_chan_b_over_pos && live |=>
    o_chan_b_data_bus == (o_cfg.twos_comp ? adc_out_pkg::TC_POS_FULL : adc_out_pkg::OB_POS_FULL))
    else $error("positive clamp wrong");
  a_neg_clamp: assert property (i_sample_valid && i_chan_b_over_neg && !i_chan_b_over_pos && live |=>
    o_chan_b_data_bus == (o_cfg.twos_comp ? adc_out_pkg::TC_NEG_FULL : adc_out_pkg::OB_NEG_FULL))
    else $error("negative clamp wrong");
  a_msb_flip: assert property (i_sample_valid && !i_chan_b_over_pos && !i_chan_b_over_neg && live |=>
    o_chan_b_data_bus == ($past(i_chan_b_sample) ^ flip))
    else $error("sample coding wrong");
  a_pin_mux: assert property (({i_reset_pin, i_power_ctrl_pin_1, i_power_ctrl_pin_2,
    i_power_ctrl_pin_3} == 4'hf)[*5] |-> o_cfg.mux)
    else $error("power pins did not select mux");
  a_strap_decode: assert property ((i_reset_pin && $stable(strap))[*5] |-> o_cfg.lvds == strap[2] &&
    o_cfg.twos_comp == (strap[2] == strap[1]) && o_cfg.low_speed == strap[0])
    else $error("strap decode wrong");
  a_reg_mux: assert property (!i_reset_pin && i_reg_write &&
    i_reg_data.pd_mode == adc_out_pkg::PD_MODE_MUX |-> ##[1:3] o_cfg.mux)
    else $error("register did not select mux");
endmodule // adc_out_checker
bind adc_output_format_and_config adc_out_checker #(.SAMPLE_W(SAMPLE_W)) chk_i (
  .i_clock               (i_clock),
  .i_reset_n             (i_reset_n),
  .i_reset_pin           (i_reset_pin),
  .i_sample_valid        (i_sample_valid),
  .i_chan_a_sample       (i_chan_a_sample),
  .i_chan_b_sample       (i_chan_b_sample),
  .i_chan_a_over_pos     (i_chan_a_over_pos),
  .i_chan_a_over_neg     (i_chan_a_over_neg),
  .i_chan_b_over_pos     (i_chan_b_over_pos),
  .i_chan_b_over_neg     (i_chan_b_over_neg),
  .i_serial_enable_level (i_serial_enable_level),
  .i_serial_clock_pin    (i_serial_clock_pin),
  .i_power_ctrl_pin_1    (i_power_ctrl_pin_1),
  .i_power_ctrl_pin_2    (i_power_ctrl_pin_2),
  .i_power_ctrl_pin_3    (i_power_ctrl_pin_3),
  .i_reg_write           (i_reg_write),
  .i_reg_data            (i_reg_data),
  .o_chan_a_data_bus_oe  (o_chan_a_data_bus_oe),
  .o_chan_b_data_bus     (o_chan_b_data_bus),
  .o_sample_out_clock    (o_sample_out_clock),
  .o_cfg                 (o_cfg)
);
`default_nettype wire

/* testbench/adc_rx_model.sv */
// Receiver model capturing words from the output buses
`timescale 1ns/1ps
`default_nettype none
module adc_rx_model (
  input  wire logic        i_clock,
  input  wire logic        i_out_clock,
  input  wire logic        i_lvds_clock,
  input  wire logic [13:0] i_bus_a,
  input  wire logic [13:0] i_bus_b,
  input  wire logic [6:0]  i_pairs_a,
  input  wire logic [6:0]  i_pairs_b,
  output var logic  [13:0] o_word_a,
  output var logic  [13:0] o_word_b,
  output var logic  [13:0] o_word_late,
  output var logic  [13:0] o_lvds_a,
  output var logic  [13:0] o_lvds_b
);
  logic       last;
  logic       last_lvds;
  logic [6:0] even_a;
  logic [6:0] even_b;
  always_ff @(posedge i_clock) begin
    last_lvds <= i_lvds_clock;
    if (i_lvds_clock && !last_lvds) begin
      even_a <= i_pairs_a;
      even_b <= i_pairs_b;
    end
    if (!i_lvds_clock && last_lvds) begin
      for (int i = 0; i < 7; i++) begin
        o_lvds_a[2*i]   <= even_a[i];
        o_lvds_a[2*i+1] <= i_pairs_a[i];
        o_lvds_b[2*i]   <= even_b[i];
        o_lvds_b[2*i+1] <= i_pairs_b[i];
      end
    end
  end
  always_ff @(posedge i_clock) begin
    last <= i_out_clock;
    if (i_out_clock && !last) begin
      o_word_a <= i_bus_a;
      o_word_b <= i_bus_b;
    end
    if (!i_out_clock && last) begin
      o_word_late <= i_bus_b;
    end
  end
endmodule // adc_rx_model
`default_nettype wire

/* testbench/adc_output_format_and_config_tb_top.sv */
// Self-checking bench for the output stage
`timescale 1ns/1ps
`default_nettype none
module adc_output_format_and_config_tb_top;
  logic clk, rst_n, rpin, valid, sclk, wr, srst, oe_a, oe_b, oclk, lclk;
  logic [13:0] sa, sb, bus_a, bus_b, wa, wb, wl, la, lb;
  logic [6:0] pa, pb;
  logic [3:0] ov;
  logic [2:0] pc;
  logic [1:0] lvl;
  adc_out_pkg::serial_regs_t rd;
  adc_out_pkg::out_cfg_t cfg;
  int failures, n_tests;
  int cyc = 0;
  localparam logic [5:0] SW = adc_out_pkg::SWING_NOMINAL;
  adc_output_format_and_config uut (.i_clock(clk), .i_reset_n(rst_n), .i_reset_pin(rpin),
    .i_sample_valid(valid), .i_chan_a_sample(sa), .i_chan_b_sample(sb),
    .i_chan_a_over_pos(ov[3]), .i_chan_a_over_neg(ov[2]), .i_chan_b_over_pos(ov[1]),
    .i_chan_b_over_neg(ov[0]), .i_serial_enable_level(lvl), .i_serial_clock_pin(sclk),
    .i_power_ctrl_pin_1(pc[0]), .i_power_ctrl_pin_2(pc[1]), .i_power_ctrl_pin_3(pc[2]),
    .i_reg_write(wr), .i_reg_data(rd), .i_soft_reset(srst), .o_chan_a_data_bus(bus_a),
    .o_chan_a_data_bus_oe(oe_a), .o_chan_b_data_bus(bus_b), .o_chan_b_data_bus_oe(oe_b),
    .o_sample_out_clock(oclk), .o_lvds_a_pairs(pa), .o_lvds_b_pairs(pb),
    .o_sample_out_clock_pos(lclk), .o_cfg(cfg));
  adc_rx_model rx (.i_clock(clk), .i_out_clock(oclk), .i_lvds_clock(lclk), .i_bus_a(bus_a),
    .i_bus_b(bus_b), .i_pairs_a(pa), .i_pairs_b(pb), .o_word_a(wa), .o_word_b(wb),
    .o_word_late(wl), .o_lvds_a(la), .o_lvds_b(lb));
  task automatic summarize();
    if (failures == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [13:0] e, input logic [13:0] g);
    n_tests++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      failures++;
    end
  endtask
  task automatic pins(input logic r, input logic [1:0] l, input logic s, input logic [2:0] p);
    @(posedge clk);
    rpin <= r;
    lvl <= l;
    sclk <= s;
    pc <= p;
    repeat (6) @(posedge clk);
  endtask
  task automatic send(input logic [13:0] a, input logic [13:0] b, input logic [3:0] o);
    @(posedge clk);
    valid <= 1'b1;
    sa <= a;
    sb <= b;
    ov <= o;
    @(posedge clk);
    valid <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic wreg(input logic s, input logic [12:0] d);
    @(posedge clk);
    wr <= !s;
    srst <= s;
    rd <= d;
    @(posedge clk);
    wr <= 1'b0;
    srst <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic t_format();
    logic tc;
    for (int l = 0; l < 4; l++) begin
      pins(1'b1, 2'(l), l[0], 3'h0);
      tc = (l[1] == l[0]);
      chk("cfg", {tc, l[1], l[0], 5'h0, SW}, cfg);
      send(14'h2345, 14'h0123, 4'h0);
      chk("word_b", {tc, 13'h0123}, wb);
      chk("word_a", {!tc, 13'h0345}, wa);
      if (l[1]) begin
        chk("lvds_b", {tc, 13'h0123}, lb);
        chk("lvds_a", {!tc, 13'h0345}, la);
      end
      send(14'h0000, 14'h0000, 4'ha);
      chk("pos_a", tc ? adc_out_pkg::TC_POS_FULL : adc_out_pkg::OB_POS_FULL, wa);
      send(14'h3fff, 14'h3fff, 4'h5);
      chk("neg_b", tc ? adc_out_pkg::TC_NEG_FULL : adc_out_pkg::OB_NEG_FULL, wb);
    end
  endtask
  task automatic t_mux();
    pins(1'b1, 2'h1, 1'b0, 3'h7);
    chk("cfg", {8'h10, SW}, cfg);
    send(14'h1555, 14'h0aaa, 4'h0);
    chk("mux_b", 14'h0aaa, wb);
    chk("mux_a", 14'h1555, wl);
    chk("oe_ab", 14'h1, {12'h0, oe_a, oe_b});
    pins(1'b1, 2'h1, 1'b0, 3'h1);
    chk("cfg", {8'h08, SW}, cfg);
    chk("oe_pd", 14'h0, {12'h0, oe_a, oe_b});
    pins(1'b1, 2'h1, 1'b0, 3'h5);
    chk("cfg", {8'h04, SW}, cfg);
    chk("oe_sb", 14'h1, {12'h0, oe_a, oe_b});
  endtask
  task automatic t_serial();
    pins(1'b0, 2'h0, 1'b0, 3'h0);
    chk("cfg", {8'h00, SW}, cfg);
    wreg(1'b0, {2'h3, 1'b0, adc_out_pkg::PD_MODE_MUX, 2'h2, 6'h2a});
    chk("cfg", {8'hd2, 6'h2a}, cfg);
    wreg(1'b0, {3'h1, 2'h0, 2'h1, 6'h15});
    chk("cfg", {8'h21, 6'h15}, cfg);
    wreg(1'b0, {3'h0, adc_out_pkg::PD_MODE_STANDBY, 2'h0, 6'h01});
    chk("cfg", {8'h04, 6'h01}, cfg);
    wreg(1'b0, {3'h0, adc_out_pkg::PD_MODE_GLOBAL, 2'h0, 6'h3f});
    chk("cfg", {8'h08, 6'h3f}, cfg);
    wreg(1'b1, 13'h0);
    chk("cfg", {8'h00, SW}, cfg);
    pins(1'b0, 2'h0, 1'b0, 3'h1);
    chk("cfg", {8'h08, SW}, cfg);
    wreg(1'b0, {3'h4, 4'h0, 6'h0c});
    chk("cfg", {8'h88, 6'h0c}, cfg);
    pins(1'b1, 2'h1, 1'b0, 3'h0);
    wreg(1'b0, {3'h4, 4'h0, 6'h0c});
    chk("cfg", {8'h00, SW}, cfg);
    pins(1'b0, 2'h0, 1'b0, 3'h0);
    chk("cfg", {8'h00, SW}, cfg);
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = !clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      failures++;
      summarize();
    end
  end
  initial begin
    {rst_n, valid, sclk, wr, srst, sa, sb, ov, pc, lvl, rd, failures, n_tests} = '0;
    rpin = 1'b1;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_format();
    t_mux();
    t_serial();
    summarize();
  end
endmodule // adc_output_format_and_config_tb_top
`default_nettype wire
